// File: logic/macro_pkg.sv
// Shared constants and carrier types for the macro output logic
package macro_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int PORT_COUNT  = 8;
    localparam int PORT_IDX_W  = 3;
    localparam int EXPR_CHARS  = 32;
    localparam int CHAR_ADDR_W = 5;
    localparam int NEST_DEPTH  = 4;

    // ------------------------------------------------------------
    // Expression character codes (ASCII)
    // ------------------------------------------------------------
    localparam logic [7:0] CH_NUL      = 8'h00;
    localparam logic [7:0] CH_TAB      = 8'h09;
    localparam logic [7:0] CH_SPACE    = 8'h20;
    localparam logic [7:0] CH_LPAREN   = 8'h28;
    localparam logic [7:0] CH_RPAREN   = 8'h29;
    localparam logic [7:0] CH_AND      = 8'h2A;
    localparam logic [7:0] CH_OR       = 8'h2B;
    localparam logic [7:0] CH_NOT      = 8'h2F;
    localparam logic [7:0] CH_OP_UPPER = 8'h49;
    localparam logic [7:0] CH_OP_LOWER = 8'h69;
    localparam logic [7:0] CH_FIRST_INPUT_OPERAND = 8'h30;
    localparam logic [7:0] CH_LAST_INPUT_OPERAND  = 8'h37;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] RST_OUT_LEVELS  = 8'h00;
    localparam logic [7:0] RST_INIT_LEVELS = 8'h00;
    localparam logic [7:0] RST_MACRO_EN    = 8'h00;
    localparam logic [7:0] RST_LOADED      = 8'h00;
    localparam logic [7:0] RST_CHAR        = 8'h00;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic                   valid;
        logic [PORT_COUNT-1:0]  mask;
        logic [PORT_COUNT-1:0]  value;
    } net_write_t;

    typedef struct packed {
        logic                   valid;
        logic [PORT_IDX_W-1:0]  port;
        logic [CHAR_ADDR_W-1:0] addr;
        logic [7:0]             char;
    } expr_char_t;

    typedef struct packed {
        logic                   valid;
        logic [PORT_IDX_W-1:0]  port;
        logic                   macroEnable;
        logic                   initLevel;
        logic                   commit;
    } port_ctl_t;

endpackage

// File: logic/macro_expr_eval.sv
// Combinational evaluator for one stored Boolean expression
`timescale 1ns/1ps
module macro_expr_eval
    import macro_pkg::*;
#(
    parameter int CHARS = EXPR_CHARS,
    parameter int DEPTH = NEST_DEPTH
) (
    input  wire logic [CHARS-1:0][7:0]     exprChars,
    input  wire logic [PORT_COUNT-1:0]     inputLevels,
    output logic                           result,
    output logic                           error
);

    // ------------------------------------------------------------
    // Per-level accumulators
    // ------------------------------------------------------------
    logic [DEPTH:0] orAcc;
    logic [DEPTH:0] andAcc;
    logic [DEPTH:0] negPend;
    logic [DEPTH:0] grpNeg;
    logic [7:0]     ch;
    logic           fac;
    logic           opPending;
    logic           done;
    logic           err;
    logic           seenOperand;
    int             lvl;

    // One left-to-right pass; the level stack keeps nesting honest
    always_comb begin
        orAcc       = '0;
        andAcc      = '1;
        negPend     = '0;
        grpNeg      = '0;
        ch          = CH_NUL;
        fac         = 1'b0;
        opPending   = 1'b0;
        done        = 1'b0;
        err         = 1'b0;
        seenOperand = 1'b0;
        lvl         = 0;
        for (int k = 0; k < CHARS; k++) begin
            ch = exprChars[k];
            if (done) begin
                fac = fac;
            end else if (opPending) begin
                opPending = 1'b0;
                if (ch >= CH_FIRST_INPUT_OPERAND && ch <= CH_LAST_INPUT_OPERAND) begin
                    // Only input pins are operands, never output levels
                    fac         = inputLevels[ch[2:0]] ^ negPend[lvl];
                    andAcc[lvl] = andAcc[lvl] & fac;
                    negPend[lvl] = 1'b0;
                    seenOperand = 1'b1;
                end else begin
                    err = 1'b1;
                end
            end else if (ch == CH_NUL) begin
                done = 1'b1;
            end else if (ch == CH_SPACE || ch == CH_TAB) begin
                done = 1'b0;
            end else if (ch == CH_OP_LOWER || ch == CH_OP_UPPER) begin
                opPending = 1'b1;
            end else if (ch == CH_NOT) begin
                negPend[lvl] = ~negPend[lvl];
            end else if (ch == CH_AND) begin
                done = 1'b0;
            end else if (ch == CH_OR) begin
                orAcc[lvl]  = orAcc[lvl] | andAcc[lvl];
                andAcc[lvl] = 1'b1;
            end else if (ch == CH_LPAREN) begin
                if (lvl == DEPTH) begin
                    err = 1'b1;
                end else begin
                    grpNeg[lvl+1]  = negPend[lvl];
                    negPend[lvl]   = 1'b0;
                    lvl            = lvl + 1;
                    orAcc[lvl]     = 1'b0;
                    andAcc[lvl]    = 1'b1;
                    negPend[lvl]   = 1'b0;
                end
            end else if (ch == CH_RPAREN) begin
                if (lvl == 0) begin
                    err = 1'b1;
                end else begin
                    // Group closes fully before its value meets outer operators
                    fac         = (orAcc[lvl] | andAcc[lvl]) ^ grpNeg[lvl];
                    lvl         = lvl - 1;
                    andAcc[lvl] = andAcc[lvl] & fac;
                end
            end else begin
                err = 1'b1;
            end
        end
        if (opPending || lvl != 0 || !seenOperand) begin
            err = 1'b1;
        end
        result = (orAcc[0] | andAcc[0]) & ~err;
        error  = err;
    end

endmodule // macro_expr_eval

// File: logic/macro_boolean_output_logic.sv
// Top of the macro-driven digital output logic
`timescale 1ns/1ps
module macro_boolean_output_logic
    import macro_pkg::*;
#(
    parameter int CHARS = EXPR_CHARS,
    parameter int DEPTH = NEST_DEPTH
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    input  wire logic [PORT_COUNT-1:0]     inputLevels,
    input  wire net_write_t                netWrite,
    input  wire expr_char_t                exprChar,
    input  wire port_ctl_t                 portCtl,
    output logic [PORT_COUNT-1:0]          outLevels_ff,
    output logic [PORT_COUNT-1:0]          macroActive_ff,
    output logic [PORT_COUNT-1:0]          exprError_ff,
    output logic [PORT_COUNT-1:0]          rejectMask_ff
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // The character address field limits how long an expression can be
    if (CHARS < 3 || CHARS > (1 << CHAR_ADDR_W)) begin : gBadChars
        $error("CHARS must lie between 3 and the character address range");
    end
    if (DEPTH < 1 || DEPTH > 16) begin : gBadDepth
        $error("DEPTH must lie between 1 and 16");
    end
    // The port field must reach every output and no more
    if (PORT_COUNT != (1 << PORT_IDX_W)) begin : gBadPorts
        $error("PORT_COUNT must fill the port index field");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [PORT_COUNT-1:0][CHARS-1:0][7:0] exprMem_ff;
    logic [PORT_COUNT-1:0][CHARS-1:0][7:0] nxt_exprMem;
    logic [PORT_COUNT-1:0]                 macroEn_ff;
    logic [PORT_COUNT-1:0]                 nxt_macroEn;
    logic [PORT_COUNT-1:0]                 initLevel_ff;
    logic [PORT_COUNT-1:0]                 nxt_initLevel;
    logic [PORT_COUNT-1:0]                 loaded_ff;
    logic [PORT_COUNT-1:0]                 nxt_loaded;
    logic [PORT_COUNT-1:0]                 nxt_outLevels;
    logic [PORT_COUNT-1:0]                 nxt_macroActive;
    logic [PORT_COUNT-1:0]                 nxt_exprError;
    logic [PORT_COUNT-1:0]                 nxt_rejectMask;
    logic [PORT_COUNT-1:0]                 evalResult;
    logic [PORT_COUNT-1:0]                 evalError;
    logic [PORT_COUNT-1:0]                 ctlHit;
    logic [PORT_COUNT-1:0]                 charHit;
    logic [PORT_COUNT-1:0]                 netHit;
    logic [PORT_COUNT-1:0]                 exprReady;
    logic [PORT_COUNT-1:0]                 exprBroken;
    logic [PORT_COUNT-1:0]                 operandLevels;

    // ------------------------------------------------------------
    // Port selection decode
    // ------------------------------------------------------------
    always_comb begin
        ctlHit = '0;
        if (portCtl.valid) begin
            ctlHit[portCtl.port] = 1'b1;
        end
    end

    always_comb begin
        charHit = '0;
        if (exprChar.valid) begin
            charHit[exprChar.port] = 1'b1;
        end
    end

    // Write bits addressed to every port; macro ports are filtered later
    always_comb begin
        netHit = '0;
        if (netWrite.valid) begin
            netHit = netWrite.mask;
        end
    end

    // ------------------------------------------------------------
    // Expression store
    // ------------------------------------------------------------
    // One character a cycle; the store is small so a flat array is cheaper
    // than a RAM with its read latency, and it lets every port evaluate at once
    always_comb begin
        nxt_exprMem = exprMem_ff;
        for (int p = 0; p < PORT_COUNT; p++) begin
            if (charHit[p]) begin
                nxt_exprMem[p][exprChar.addr] = exprChar.char;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            exprMem_ff <= {(PORT_COUNT * CHARS){RST_CHAR}};
        end else begin
            exprMem_ff <= nxt_exprMem;
        end
    end

    // ------------------------------------------------------------
    // Macro enable per port
    // ------------------------------------------------------------
    always_comb begin
        nxt_macroEn = macroEn_ff;
        for (int p = 0; p < PORT_COUNT; p++) begin
            if (ctlHit[p]) begin
                nxt_macroEn[p] = portCtl.macroEnable;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            macroEn_ff <= RST_MACRO_EN;
        end else begin
            macroEn_ff <= nxt_macroEn;
        end
    end

    // ------------------------------------------------------------
    // Initial level per port
    // ------------------------------------------------------------
    always_comb begin
        nxt_initLevel = initLevel_ff;
        for (int p = 0; p < PORT_COUNT; p++) begin
            if (ctlHit[p]) begin
                nxt_initLevel[p] = portCtl.initLevel;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            initLevel_ff <= RST_INIT_LEVELS;
        end else begin
            initLevel_ff <= nxt_initLevel;
        end
    end

    // ------------------------------------------------------------
    // Loaded flag per port
    // ------------------------------------------------------------
    always_comb begin
        nxt_loaded = loaded_ff;
        for (int p = 0; p < PORT_COUNT; p++) begin
            // Editing an expression withdraws it until it is committed again,
            // so a half-written text never reaches a pin
            if (charHit[p]) begin
                nxt_loaded[p] = 1'b0;
            end
            // A commit in the same cycle as an edit wins, so the set comes last
            if (ctlHit[p] && portCtl.commit) begin
                nxt_loaded[p] = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            loaded_ff <= RST_LOADED;
        end else begin
            loaded_ff <= nxt_loaded;
        end
    end

    // ------------------------------------------------------------
    // Operand view
    // ------------------------------------------------------------
    // Only input pins form the operand set; output levels stay out so
    // no macro can hold itself up through its own pin
    always_comb begin
        operandLevels = inputLevels;
    end

    // ------------------------------------------------------------
    // Evaluators, one per output port
    // ------------------------------------------------------------
    for (genvar g = 0; g < PORT_COUNT; g++) begin : gEval
        macro_expr_eval #(
            .CHARS       (CHARS),
            .DEPTH       (DEPTH)
        ) uEval (
            .exprChars   (exprMem_ff[g]),
            .inputLevels (operandLevels),
            .result      (evalResult[g]),
            .error       (evalError[g])
        );
    end

    // ------------------------------------------------------------
    // Port state summary
    // ------------------------------------------------------------
    // A port follows its text only once committed and well formed
    always_comb begin
        exprReady  = '0;
        exprBroken = '0;
        for (int p = 0; p < PORT_COUNT; p++) begin
            if (macroEn_ff[p] && loaded_ff[p]) begin
                exprReady[p]  = ~evalError[p];
                exprBroken[p] = evalError[p];
            end
        end
    end

    // ------------------------------------------------------------
    // Output levels
    // ------------------------------------------------------------
    // Inputs are taken as synchronous, so a pin change shows at the output
    // one edge later; no filtering is done here
    always_comb begin
        nxt_outLevels = outLevels_ff;
        for (int p = 0; p < PORT_COUNT; p++) begin
            if (ctlHit[p] && !portCtl.macroEnable) begin
                // Leaving macro mode hands the pin back at its initial level
                nxt_outLevels[p] = portCtl.initLevel;
            end else if (macroEn_ff[p]) begin
                if (exprReady[p]) begin
                    nxt_outLevels[p] = evalResult[p];
                end else begin
                    // A broken text falls back to the safe level, not a guess
                    nxt_outLevels[p] = initLevel_ff[p];
                end
            end else if (ctlHit[p]) begin
                nxt_outLevels[p] = portCtl.initLevel;
            end else if (netHit[p]) begin
                nxt_outLevels[p] = netWrite.value[p];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            outLevels_ff <= RST_OUT_LEVELS;
        end else begin
            outLevels_ff <= nxt_outLevels;
        end
    end

    // ------------------------------------------------------------
    // Macro active flags
    // ------------------------------------------------------------
    always_comb begin
        nxt_macroActive = exprReady;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            macroActive_ff <= '0;
        end else begin
            macroActive_ff <= nxt_macroActive;
        end
    end

    // ------------------------------------------------------------
    // Expression error flags
    // ------------------------------------------------------------
    always_comb begin
        nxt_exprError = exprBroken;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            exprError_ff <= '0;
        end else begin
            exprError_ff <= nxt_exprError;
        end
    end

    // ------------------------------------------------------------
    // Refused network writes
    // ------------------------------------------------------------
    // Macro ports never take a network level; the refusal is only reported
    always_comb begin
        nxt_rejectMask = netHit & macroEn_ff;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rejectMask_ff <= '0;
        end else begin
            rejectMask_ff <= nxt_rejectMask;
        end
    end

endmodule // macro_boolean_output_logic

// File: sim/macro_boolean_output_logic_monitor.sv
// Port checker for the macro output logic, bound to its top
`timescale 1ns/1ps
module macro_output_monitor
    import macro_pkg::*;
(
    input wire logic                  core_clk,
    input wire logic                  rst,
    input wire logic [PORT_COUNT-1:0] inputLevels,
    input wire net_write_t            netWrite,
    input wire expr_char_t            exprChar,
    input wire port_ctl_t             portCtl,
    input wire logic [PORT_COUNT-1:0] outLevels_ff,
    input wire logic [PORT_COUNT-1:0] macroActive_ff,
    input wire logic [PORT_COUNT-1:0] exprError_ff,
    input wire logic [PORT_COUNT-1:0] rejectMask_ff
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic quiet;
    assign quiet = !netWrite.valid && !exprChar.valid && !portCtl.valid;
    sequence s_commit;
        portCtl.valid && portCtl.macroEnable && portCtl.commit && !exprChar.valid;
    endsequence
    sequence s_still;
        !exprChar.valid && !portCtl.valid;
    endsequence
    property p_reset;
        $fell(rst) |-> outLevels_ff == RST_OUT_LEVELS && macroActive_ff == 8'h00;
    endproperty
    property p_reject;
        netWrite.valid && !portCtl.valid && (netWrite.mask & macroActive_ff) != 8'h00
        |=> (rejectMask_ff & $past(netWrite.mask & macroActive_ff))
            == $past(netWrite.mask & macroActive_ff);
    endproperty
    property p_rejCause;
        rejectMask_ff != 8'h00
        |-> $past(netWrite.valid) && (rejectMask_ff & ~$past(netWrite.mask)) == 8'h00;
    endproperty
    property p_applied;
        netWrite.valid && !portCtl.valid
        |=> ((outLevels_ff ^ $past(netWrite.value)) & $past(netWrite.mask)
            & ~rejectMask_ff) == 8'h00;
    endproperty
    property p_ctlPlain;
        logic [2:0] p;
        logic       v;
        (portCtl.valid && !portCtl.macroEnable, p = portCtl.port, v = portCtl.initLevel)
        |=> outLevels_ff[p] == v;
    endproperty
    property p_unload;
        logic [2:0] p;
        (exprChar.valid, p = exprChar.port) |-> ##2 !macroActive_ff[p];
    endproperty
    property p_commit;
        logic [2:0] p;
        (s_commit, p = portCtl.port) ##1 s_still |=> macroActive_ff[p] || exprError_ff[p];
    endproperty
    property p_quiet;
        (quiet && $stable(inputLevels)) [*3] |=> $stable(outLevels_ff);
    endproperty
    property p_errExcl;
        (exprError_ff & macroActive_ff) == 8'h00;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared");
    a_reject: assert property (p_reject) else $error("macro bit not refused");
    a_rejCause: assert property (p_rejCause) else $error("refusal without write");
    a_applied: assert property (p_applied) else $error("plain write lost");
    a_ctlPlain: assert property (p_ctlPlain) else $error("initial level missed");
    a_unload: assert property (p_unload) else $error("stale expression active");
    a_commit: assert property (p_commit) else $error("commit not taken");
    a_quiet: assert property (p_quiet) else $error("output moved by itself");
    a_errExcl: assert property (p_errExcl) else $error("error and active both set");
endmodule // macro_output_monitor

bind macro_boolean_output_logic macro_output_monitor u_mon (
    .core_clk(core_clk), .rst(rst), .inputLevels(inputLevels), .netWrite(netWrite),
    .exprChar(exprChar), .portCtl(portCtl), .outLevels_ff(outLevels_ff),
    .macroActive_ff(macroActive_ff), .exprError_ff(exprError_ff),
    .rejectMask_ff(rejectMask_ff)
);

// File: sim/io_port_model.sv
// Model of the input pin drivers that feed the block
`timescale 1ns/1ps
module io_port_model
    import macro_pkg::*;
(
    input  wire logic [PORT_COUNT-1:0] pinWant,
    output logic      [PORT_COUNT-1:0] inputLevels
);
    // Pins are driven push-pull, so they always show a defined level
    assign inputLevels = pinWant;
endmodule // io_port_model

// File: sim/tb.sv
// Self-checking bench for the macro output logic
`timescale 1ns/1ps
module tb
    import macro_pkg::*;
;
    typedef struct {int cyc; logic [7:0] mask; logic [7:0] val;} note_t;
    logic       core_clk, rst;
    logic [7:0] pinWant, inputLevels, outLevels_ff, macroActive_ff;
    logic [7:0] exprError_ff, rejectMask_ff, x, w;
    net_write_t netWrite;
    expr_char_t exprChar;
    port_ctl_t  portCtl;
    note_t      q[$];
    int         cyc, fails, tests_run;

    io_port_model u_pins (.pinWant(pinWant), .inputLevels(inputLevels));
    macro_boolean_output_logic dut (
        .core_clk(core_clk), .rst(rst), .inputLevels(inputLevels), .netWrite(netWrite),
        .exprChar(exprChar), .portCtl(portCtl), .outLevels_ff(outLevels_ff),
        .macroActive_ff(macroActive_ff), .exprError_ff(exprError_ff),
        .rejectMask_ff(rejectMask_ff));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] ev(input logic [7:0] i);
        return {i[5] | (i[6] & i[7]), i[0] & ~(i[1] | i[7]), (i[2] & i[3]) | ~i[4], i[0] | i[1]};
    endfunction
    task check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task note(input int d, input logic [7:0] m, input logic [7:0] v);
        q.push_back('{cyc + d, m, v});
    endtask
    task ctl(input logic [2:0] p, input logic me, input logic il, input logic cm);
        portCtl <= '{1'b1, p, me, il, cm};
        @(negedge core_clk);
        portCtl <= '0;
    endtask
    task load(input logic [2:0] p, input string s, input logic il);
        for (int k = 0; k <= s.len(); k++) begin
            exprChar <= '{1'b1, p, k[4:0], (k < s.len()) ? 8'(s[k]) : CH_NUL};
            @(negedge core_clk);
        end
        exprChar <= '0;
        ctl(p, 1'b1, il, 1'b1);
    endtask
    task results;
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
    end
    // Oldest note is due once its cycle is reached
    always @(negedge core_clk) begin
        while (q.size() > 0 && q[0].cyc <= cyc) begin
            check(outLevels_ff & q[0].mask, q[0].val & q[0].mask);
            void'(q.pop_front());
        end
    end
    initial begin
        repeat (4000) @(posedge core_clk);
        fails++;
        results();
    end

    initial begin
        rst = 1'b1;
        pinWant = 8'h00;
        netWrite = '0;
        exprChar = '0;
        portCtl = '0;
        cyc = 0;
        fails = 0;
        tests_run = 0;
        void'($urandom(3));
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        check(outLevels_ff | macroActive_ff | rejectMask_ff, RST_OUT_LEVELS);
        w = 8'($urandom);
        netWrite <= '{1'b1, 8'hFF, w};
        note(1, 8'hFF, w);
        @(negedge core_clk);
        netWrite <= '0;
        load(3'h0, "i0 + i1", 1'b0);
        load(3'h1, "((i2*I3) +/i4)", 1'b0);
        load(3'h2, "I0 * /(i1 + i7)", 1'b0);
        load(3'h3, "i5+i6*i7", 1'b0);
        repeat (3) @(negedge core_clk);
        check(macroActive_ff, 8'h0F);
        // Random pins exercise every operator truth table
        for (int n = 0; n < 40; n++) begin
            x = 8'($urandom);
            pinWant <= x;
            note(1, 8'hFF, {w[7:4], ev(x)});
            @(negedge core_clk);
        end
        @(negedge core_clk);
        w = 8'($urandom);
        netWrite <= '{1'b1, 8'hFF, w};
        note(1, 8'hFF, {w[7:4], ev(x)});
        @(negedge core_clk);
        netWrite <= '0;
        check(rejectMask_ff, 8'h0F);
        ctl(3'h4, 1'b1, ~w[4], 1'b0);
        note(2, 8'h10, {3'h0, ~w[4], 4'h0});
        load(3'h5, "i8", 1'b1);
        repeat (2) @(negedge core_clk);
        check(exprError_ff, 8'h20);
        check(outLevels_ff & 8'h20, 8'h20);
        // Control and write in one cycle: control must win
        netWrite <= '{1'b1, 8'h40, {1'b0, w[6], 6'h00}};
        ctl(3'h6, 1'b0, ~w[6], 1'b0);
        netWrite <= '0;
        check(outLevels_ff & 8'h40, {1'b0, ~w[6], 6'h00});
        repeat (6) @(negedge core_clk);
        check(outLevels_ff & 8'h0F, {4'h0, ev(x)});
        results();
    end
endmodule // tb
